//--- core/dtcs_pkg.sv
// dtcs_pkg: constants and types for the transfer cycle sequencer
// assumes: one clock domain, synchronous active-high reset
package dtcs_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int WAIT_W = 2;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_AW = 3;
    // bus cycles for one side of a unit: one when even or byte, two for an odd 16-bit word
    localparam logic [1:0] CYC_EVEN = 2'h1;
    localparam logic [1:0] CYC_ODD16 = 2'h2;
    localparam logic [WAIT_W-1:0] WAIT_NONE = 2'h0;
    typedef enum logic [2:0] {
        DTCS_IDLE,
        DTCS_RD,
        DTCS_WR,
        DTCS_DONE
    } dtcs_state_type;
endpackage

//--- core/dtcs_fifo.sv
// dtcs_fifo: small synchronous fifo with valid/ready on both sides
// assumes: one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module dtcs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic [WIDTH-1:0] dout_r;
    logic push;
    logic pop;
    logic [AW-1:0] rp_nxt;

    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign rp_nxt = pop ? rp_r + AW'(1) : rp_r;
    assign out_data = dout_r;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + AW'(1);
            end
            if (pop) begin
                rp_r <= rp_r + AW'(1);
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // head word kept in a register; a push that becomes the head goes straight in
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dout_r <= '0;
        end else if (push && wp_r == rp_nxt) begin
            dout_r <= in_data;
        end else begin
            dout_r <= mem_r[rp_nxt];
        end
    end
endmodule
`default_nettype wire

//--- core/dtcs_seq.sv
// dtcs_seq: bus-cycle sequencer for one dma transfer unit
// assumes: bus granted by arbiter via bus_grant; each bus cycle ends once its wait count is spent
`timescale 1ns/1ps
`default_nettype none
module dtcs_seq
    import dtcs_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // unit requests from channel logic
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [dtcs_pkg::ADDR_W-1:0] req_src,
    input wire logic [dtcs_pkg::ADDR_W-1:0] req_dst,
    input wire logic req_byte,
    input wire logic [dtcs_pkg::WAIT_W-1:0] req_src_wait,
    input wire logic [dtcs_pkg::WAIT_W-1:0] req_dst_wait,
    // internal bus
    output logic bus_req,
    input wire logic bus_grant,
    output logic [dtcs_pkg::ADDR_W-1:0] bus_addr,
    output logic bus_rd,
    output logic bus_wr,
    output logic bus_byte,
    output logic [dtcs_pkg::DATA_W-1:0] bus_wdata,
    input wire logic [7:0] bus_rdata_lo,
    input wire logic [dtcs_pkg::DATA_W-1:0] bus_rdata,
    // completion
    output logic done_valid,
    input wire logic done_ready,
    output logic [dtcs_pkg::DATA_W-1:0] done_data
);
    import dtcs_pkg::*;

    dtcs_state_type state_r;
    logic [ADDR_W-1:0] src_r;
    logic [ADDR_W-1:0] dst_r;
    logic byte_r;
    logic [WAIT_W-1:0] sw_r;
    logic [WAIT_W-1:0] dw_r;
    logic [1:0] ncyc_r;
    logic [1:0] cyc_r;
    logic [WAIT_W-1:0] wcnt_r;
    logic [DATA_W-1:0] data_r;
    logic [7:0] lat_r;
    logic [DATA_W-1:0] bus_wdata_r;
    logic [DATA_W-1:0] rd_word;
    logic [ADDR_W-1:0] bus_addr_r;
    logic [1:0] wcyc;
    logic step;
    logic last_cyc;
    logic fifo_in_ready;
    logic [4:0] unit_cnt_r;

    // --------------------------------------------------------------
    // bus cycle pacing
    // --------------------------------------------------------------
    // one bus cycle ends once its wait count has been spent
    assign step = bus_grant && (state_r == DTCS_RD || state_r == DTCS_WR)
        && (wcnt_r == ((state_r == DTCS_RD) ? sw_r : dw_r));
    assign last_cyc = (cyc_r == ncyc_r - 2'h1);
    assign req_ready = (state_r == DTCS_IDLE);
    assign bus_req = (state_r == DTCS_RD) || (state_r == DTCS_WR);
    assign bus_rd = bus_grant && (state_r == DTCS_RD);
    assign bus_wr = bus_grant && (state_r == DTCS_WR);
    assign bus_byte = byte_r || (ncyc_r == CYC_ODD16);
    assign bus_addr = bus_addr_r;
    assign bus_wdata = bus_wdata_r;
    // write side count for the destination
    assign wcyc = (!byte_r && dst_r[0]) ? CYC_ODD16 : CYC_EVEN;
    // word as it stands at the last read cycle; an odd source pairs the latched low byte
    assign rd_word = byte_r ? {8'h00, bus_rdata_lo}
        : ((ncyc_r == CYC_ODD16) ? {bus_rdata_lo, lat_r} : bus_rdata);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= DTCS_IDLE;
            cyc_r <= 2'h0;
            wcnt_r <= WAIT_NONE;
            ncyc_r <= CYC_EVEN;
        end else begin
            case (state_r)
                DTCS_IDLE: begin
                    if (req_valid) begin
                        state_r <= DTCS_RD;
                        cyc_r <= 2'h0;
                        wcnt_r <= WAIT_NONE;
                        ncyc_r <= (!req_byte && req_src[0]) ? CYC_ODD16 : CYC_EVEN;
                    end
                end
                DTCS_RD: begin
                    if (bus_grant) begin
                        if (!step) begin
                            wcnt_r <= wcnt_r + WAIT_W'(1);
                        end else if (!last_cyc) begin
                            wcnt_r <= WAIT_NONE;
                            cyc_r <= cyc_r + 2'h1;
                        end else begin
                            // reads all done, data held, now writes
                            state_r <= DTCS_WR;
                            wcnt_r <= WAIT_NONE;
                            cyc_r <= 2'h0;
                            ncyc_r <= wcyc;
                        end
                    end
                end
                DTCS_WR: begin
                    if (bus_grant) begin
                        if (!step) begin
                            wcnt_r <= wcnt_r + WAIT_W'(1);
                        end else if (!last_cyc) begin
                            wcnt_r <= WAIT_NONE;
                            cyc_r <= cyc_r + 2'h1;
                        end else begin
                            state_r <= DTCS_DONE;
                        end
                    end
                end
                DTCS_DONE: begin
                    if (fifo_in_ready) begin
                        state_r <= DTCS_IDLE;
                    end
                end
                default: begin
                    state_r <= DTCS_IDLE;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // unit capture, address and data
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            src_r <= '0;
            dst_r <= '0;
            byte_r <= 1'b0;
            sw_r <= WAIT_NONE;
            dw_r <= WAIT_NONE;
        end else if (state_r == DTCS_IDLE && req_valid) begin
            src_r <= req_src;
            dst_r <= req_dst;
            byte_r <= req_byte;
            sw_r <= req_src_wait;
            dw_r <= req_dst_wait;
        end
    end

    // address for the cycle in progress: base plus cycle index
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_addr_r <= '0;
        end else if (state_r == DTCS_IDLE && req_valid) begin
            bus_addr_r <= req_src;
        end else if (step && !last_cyc) begin
            bus_addr_r <= bus_addr_r + ADDR_W'(1);
        end else if (step && state_r == DTCS_RD) begin
            bus_addr_r <= dst_r;
        end
    end

    // read data held until the write side has finished
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            data_r <= '0;
            lat_r <= '0;
        end else if (step && state_r == DTCS_RD) begin
            if (ncyc_r == CYC_ODD16 && !last_cyc) begin
                lat_r <= bus_rdata_lo;
            end else begin
                data_r <= rd_word;
            end
        end
    end

    // whole word for an even write; split writes carry low byte, then high byte
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_wdata_r <= '0;
        end else if (step && state_r == DTCS_RD && last_cyc) begin
            bus_wdata_r <= (wcyc == CYC_ODD16) ? {8'h00, rd_word[7:0]} : rd_word;
        end else if (step && state_r == DTCS_WR && !last_cyc) begin
            bus_wdata_r <= {8'h00, data_r[15:8]};
        end
    end

    // --------------------------------------------------------------
    // total cycle count of the unit, for the checks below
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            unit_cnt_r <= '0;
        end else if (state_r == DTCS_IDLE) begin
            unit_cnt_r <= '0;
        end else if (bus_rd || bus_wr) begin
            unit_cnt_r <= unit_cnt_r + 5'h1;
        end
    end

    // --------------------------------------------------------------
    // completion fifo
    // --------------------------------------------------------------
    dtcs_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(state_r == DTCS_DONE),
        .in_ready(fifo_in_ready),
        .in_data(data_r),
        .out_valid(done_valid),
        .out_ready(done_ready),
        .out_data(done_data)
    );

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    sequence rd_end_s;
        step && state_r == DTCS_RD && last_cyc;
    endsequence

    rd_then_wr_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_end_s |=> state_r == DTCS_WR)
        else $error("write did not follow read");
    rd_data_held_a: assert property (@(posedge sys_clk) disable iff (rst)
        state_r == DTCS_WR |=> $stable(data_r))
        else $error("read data changed during writes");
    odd_src_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state_r == DTCS_IDLE && req_valid && !req_byte && req_src[0])
        |=> ncyc_r == CYC_ODD16)
        else $error("odd source not split");
    even_src_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state_r == DTCS_IDLE && req_valid && (req_byte || !req_src[0]))
        |=> ncyc_r == CYC_EVEN)
        else $error("even source split");
    odd_dst_a: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_end_s and (!byte_r && dst_r[0])) |=> ncyc_r == CYC_ODD16)
        else $error("odd destination not split");
    wait_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        (bus_rd && wcnt_r < sw_r) |=> state_r == DTCS_RD && $stable(cyc_r))
        else $error("read cycle ended before wait");
    unit_total_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state_r == DTCS_DONE && $changed(state_r)) |->
        unit_cnt_r == 5'((((!byte_r && src_r[0]) ? 2 : 1) * (sw_r + 1))
            + (((!byte_r && dst_r[0]) ? 2 : 1) * (dw_r + 1))))
        else $error("unit cycle count wrong");
    done_push_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state_r == DTCS_DONE && fifo_in_ready) |=> state_r == DTCS_IDLE)
        else $error("unit not retired");
endmodule
`default_nettype wire

//--- test/dtcs_bus_model.sv
// dtcs_bus_model: memory and register bus seen from the sequencer
// assumes: one clock; grant changes at the falling edge; tb reads the counters
`timescale 1ns/1ps
`default_nettype none
module dtcs_bus_model
    import dtcs_pkg::*;
(
    // clock and control from the bench
    input wire logic sys_clk,
    input wire logic clr,
    input wire logic slow,
    // bus from the sequencer
    input wire logic bus_req,
    input wire logic [dtcs_pkg::ADDR_W-1:0] bus_addr,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic bus_byte,
    input wire logic [dtcs_pkg::DATA_W-1:0] bus_wdata,
    output logic bus_grant,
    output logic [7:0] bus_rdata_lo,
    output logic [dtcs_pkg::DATA_W-1:0] bus_rdata,
    // observation
    output logic [7:0] rd_n,
    output logic [7:0] wr_n,
    output logic order_err
);
    import dtcs_pkg::*;
    logic [7:0] wmem [256];
    logic [15:0] last_r = 16'h0;

    function automatic logic [7:0] mb(input logic [19:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction

    initial begin
        bus_grant = 1'b0;
        rd_n = 8'h0;
        wr_n = 8'h0;
        order_err = 1'b0;
    end
    // slow mode grants only every other cycle
    always @(negedge sys_clk) begin
        bus_grant <= bus_req & (~slow | ~bus_grant);
    end
    // outside a read the data lines show a changing pattern, never the old value
    always_comb begin
        if (bus_rd) begin
            bus_rdata = {mb(bus_addr + 20'h1), mb(bus_addr)};
            bus_rdata_lo = mb(bus_addr);
        end else begin
            bus_rdata = ~last_r;
            bus_rdata_lo = ~last_r[7:0];
        end
    end
    always @(posedge sys_clk) begin
        last_r <= bus_rdata;
        if (clr) begin
            rd_n <= 8'h0;
            wr_n <= 8'h0;
            order_err <= 1'b0;
            for (int i = 0; i < 256; i++) wmem[i] <= 8'h00;
        end else begin
            if (bus_rd & bus_grant) begin
                rd_n <= rd_n + 8'h1;
                if (wr_n != 8'h0) order_err <= 1'b1;
            end
            if (bus_wr & bus_grant) begin
                wr_n <= wr_n + 8'h1;
                wmem[bus_addr[7:0]] <= bus_wdata[7:0];
                if (!bus_byte) wmem[bus_addr[7:0] + 8'h1] <= bus_wdata[15:8];
            end
            if (bus_rd & bus_wr) order_err <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- test/dtcs_seq_tb.sv
// dtcs_seq_tb: self-checking bench for the transfer cycle sequencer
// assumes: bus model answers every access; inputs change at falling edges
`timescale 1ns/1ps
`default_nettype none
module dtcs_seq_tb;
    import dtcs_pkg::*;
    logic sys_clk = 0, rst = 1, req_valid = 0, req_byte = 0, done_ready = 0, slow = 0, clr = 0;
    logic [ADDR_W-1:0] req_src = '0, req_dst = '0, bus_addr;
    logic [WAIT_W-1:0] req_src_wait = '0, req_dst_wait = '0;
    logic req_ready, bus_req, bus_grant, bus_rd, bus_wr, bus_byte, done_valid, order_err;
    logic [7:0] bus_rdata_lo, rd_n, wr_n;
    logic [DATA_W-1:0] bus_rdata, done_data, bus_wdata;
    int n_fail = 0, samples_checked = 0;
    bit hung = 0;

    dtcs_seq dtcs_seq_i (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req_src(req_src), .req_dst(req_dst), .req_byte(req_byte),
        .req_src_wait(req_src_wait), .req_dst_wait(req_dst_wait), .bus_req(bus_req),
        .bus_grant(bus_grant), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
        .bus_byte(bus_byte), .bus_wdata(bus_wdata), .bus_rdata_lo(bus_rdata_lo),
        .bus_rdata(bus_rdata), .done_valid(done_valid), .done_ready(done_ready),
        .done_data(done_data));
    dtcs_bus_model dtcs_bus_model_i (.sys_clk(sys_clk), .clr(clr), .slow(slow),
        .bus_req(bus_req), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
        .bus_byte(bus_byte), .bus_wdata(bus_wdata), .bus_grant(bus_grant),
        .bus_rdata_lo(bus_rdata_lo),
        .bus_rdata(bus_rdata), .rd_n(rd_n), .wr_n(wr_n), .order_err(order_err));

    initial forever #4 sys_clk = ~sys_clk;

    function automatic logic [7:0] mb(input logic [19:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one unit: request, wait for idle, then judge cycle counts and written bytes; with idle clear, only check that ready stays low 30 cycles later
    task automatic issue(input logic [19:0] s, d, input logic b, input logic [1:0] sw, dw,
                         input bit idle);
        int k;
        logic [7:0] nrd, nwr;
        if (hung) return;
        @(negedge sys_clk);
        {clr, req_valid, req_src, req_dst, req_byte} = {2'b11, s, d, b};
        {req_src_wait, req_dst_wait} = {sw, dw};
        // ready seen at a falling edge means the next rising edge takes the request
        k = 0;
        while (req_ready !== 1'b1 && k < 50) begin
            @(negedge sys_clk);
            k++;
        end
        @(negedge sys_clk);
        {clr, req_valid} = 2'b00;
        if (k == 50) begin
            n_fail++;
            hung = 1;
            return;
        end
        if (!idle) begin
            repeat (30) @(negedge sys_clk);
            chk("held off while full", 0, req_ready);
            return;
        end
        k = 0;
        while (req_ready !== 1'b1 && k < 60) begin
            @(negedge sys_clk);
            k++;
        end
        if (k == 60) begin
            n_fail++;
            hung = 1;
            return;
        end
        nrd = (!b && s[0]) ? 8'd2 * (sw + 8'd1) : sw + 8'd1;
        nwr = (!b && d[0]) ? 8'd2 * (dw + 8'd1) : dw + 8'd1;
        chk("read cycles", nrd, rd_n);
        chk("write cycles", nwr, wr_n);
        chk("read before write", 0, order_err);
        if (b) chk("byte written", mb(s), dtcs_bus_model_i.wmem[d[7:0]]);
        else begin
            chk("low byte written", mb(s), dtcs_bus_model_i.wmem[d[7:0]]);
            chk("high byte written", mb(s + 20'h1),
                dtcs_bus_model_i.wmem[d[7:0] + 8'h1]);
        end
    endtask

    task automatic pop(input logic [19:0] s, input logic b);
        int k;
        if (hung) return;
        k = 0;
        @(negedge sys_clk);
        while (done_valid !== 1'b1 && k < 40) begin
            @(negedge sys_clk);
            k++;
        end
        if (k == 40) begin
            n_fail++;
            hung = 1;
            return;
        end
        if (b) chk("byte read", {8'h00, mb(s)}, done_data);
        else chk("word read", {mb(s + 20'h1), mb(s)}, done_data);
        done_ready = 1;
        @(negedge sys_clk);
        done_ready = 0;
    endtask

    task automatic t_parity();
        for (int i = 0; i < 8; i++) begin
            issue(20'h00120 + i[2:1], 20'h00240 + i[1:0], i[2], 2'h0, 2'h0, 1);
            pop(20'h00120 + i[2:1], i[2]);
        end
        $display("test parity done");
    endtask

    task automatic t_waits();
        for (int i = 0; i < 16; i++) begin
            issue(20'h00331, 20'h00453, 0, i[3:2], i[1:0], 1);
            pop(20'h00331, 0);
        end
        $display("test waits done");
    endtask

    task automatic t_slow();
        slow = 1;
        issue(20'h00517, 20'h00629, 0, 2'h1, 2'h2, 1);
        pop(20'h00517, 0);
        issue(20'h00700, 20'h00711, 1, 2'h3, 2'h0, 1);
        pop(20'h00700, 1);
        slow = 0;
        $display("test slow grant done");
    endtask

    task automatic t_fill();
        for (int i = 0; i < 8; i++) issue(20'h00800 + 2 * i, 20'h00900, 0, 2'h0, 2'h0, 1);
        issue(20'h00810, 20'h00900, 0, 2'h0, 2'h0, 0);
        for (int i = 0; i < 9; i++) pop(20'h00800 + 2 * i, 0);
        $display("test fill done");
    endtask

    initial begin
        repeat (12) @(negedge sys_clk);
        rst = 0;
        t_parity();
        t_waits();
        t_slow();
        t_fill();
        complete_run();
    end
endmodule
`default_nettype wire
